/* dv/fso_host_model.sv */
// Host controller model issuing mode-0 command frames
`timescale 1ns/1ps
module fso_host_model (
    // Serial link
    output logic      sck,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso_out,
    input  wire logic miso_oe_n
);
    logic junk = 1'b0;
    // A released line flips each edge so a stale bit never reads as data
    wire  line = miso_oe_n ? junk : miso_out;
    // Deselect after time zero so the frame logic sees a real select edge
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        #1 cs_n = 1'b1;
    end
    always @(sck) junk <= ~junk;
    // Clock runs only inside frames, bytes go out most significant bit first
    task automatic xfer(input logic [7:0] tx[$], input int nrd, output logic [7:0] rx);
        logic [7:0] b;
        cs_n = 1'b0;
        for (int i = 0; i < tx.size() + nrd; i++) begin
            b = (i < tx.size()) ? tx[i] : 8'h00;
            for (int k = 7; k >= 0; k--) begin
                mosi = b[k];
                #7.5 sck = 1'b1;
                rx = {rx[6:0], line};
                #7.5 sck = 1'b0;
            end
        end
        #7.5 cs_n = 1'b1;
        #100;
    endtask
endmodule

/* dv/fso_status_one_asserts.sv */
// Concurrent checks on the status register block ports
`timescale 1ns/1ps
module fso_status_one_asserts
    import fso_pkg::*;
(
    // Core clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Store and engine
    input wire logic [7:0]  status_one_nonvolatile,
    input wire logic        op_start,
    input wire fso_state_e  op_kind,
    input wire logic [2:0]  active_protect,
    input wire logic        suspend_req,
    input wire logic        abort_req,
    input wire logic        op_done,
    input wire logic        op_fail,
    input wire logic        op_prot_hit,
    // Register view
    input wire fso_status_s status_one_volatile
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic run_reg;
    wire  bad = op_done && run_reg && (op_fail || op_prot_hit);
    wire  ok  = op_done && run_reg && !op_fail && !op_prot_hit;
    // Tracks an engine run so stray done pulses are not judged
    always_ff @(posedge core_clk) begin
        if (!rst_n || op_done || abort_req) run_reg <= 1'b0;
        else if (op_start) run_reg <= 1'b1;
    end
    property p_mirror;
        $changed(status_one_nonvolatile[7]) |-> ##[1:3]
            status_one_volatile.register_lock_mirror == status_one_nonvolatile[7];
    endproperty
    property p_start;
        op_start |-> !$past(status_one_volatile.write_in_progress) &&
            status_one_volatile.write_in_progress && status_one_volatile.write_enable_latch;
    endproperty
    property p_bulk;
        op_start && op_kind == ST_BULK |-> active_protect == 3'h0;
    endproperty
    property p_done_ok;
        ok |=> !status_one_volatile.write_enable_latch && !status_one_volatile.write_in_progress;
    endproperty
    property p_prog_err;
        bad && op_kind == ST_PROGRAM |=> status_one_volatile.program_error &&
            status_one_volatile.write_in_progress;
    endproperty
    property p_erase_err;
        bad && op_kind == ST_ERASE |=> status_one_volatile.erase_error;
    endproperty
    property p_bulk_noerr;
        op_done && run_reg && op_kind == ST_BULK && !op_fail |=> !status_one_volatile.erase_error;
    endproperty
    property p_err_busy;
        status_one_volatile.program_error || status_one_volatile.erase_error
            |-> status_one_volatile.write_in_progress;
    endproperty
    property p_err_rise;
        $rose(status_one_volatile.program_error) |-> $past(op_done) &&
            status_one_volatile.write_in_progress;
    endproperty
    property p_susp;
        suspend_req |-> run_reg && status_one_volatile.write_in_progress;
    endproperty
    a_mirror: assert property (p_mirror) else $error("lock mirror stale");
    a_start: assert property (p_start) else $error("start while busy or disabled");
    a_bulk: assert property (p_bulk) else $error("bulk erase while protected");
    a_done_ok: assert property (p_done_ok) else $error("success left latch or busy");
    a_prog_err: assert property (p_prog_err) else $error("program error missed");
    a_erase_err: assert property (p_erase_err) else $error("erase error missed");
    a_bulk_noerr: assert property (p_bulk_noerr) else $error("bulk set erase error");
    a_err_busy: assert property (p_err_busy) else $error("error without busy");
    a_err_rise: assert property (p_err_rise) else $error("error rose without result");
    a_susp: assert property (p_susp) else $error("suspend with no run");
    c_prog: cover property (op_start && op_kind == ST_PROGRAM);
    c_bulk: cover property (op_start && op_kind == ST_BULK);
    c_susp: cover property (suspend_req);
    c_abort: cover property (abort_req);
endmodule

bind fso_status_one fso_status_one_asserts fso_status_one_asserts_inst (.*);

/* dv/tb_fso_status_one.sv */
// Self-checking bench for the volatile first status register
`timescale 1ns/1ps
module tb_fso_status_one;
    import fso_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n;
    logic        wp_n = 1'b1;
    logic [7:0]  nv_st = 8'h9C;
    logic [7:0]  nv_cf = 8'h00;
    logic        op_done = 1'b0;
    logic        op_fail = 1'b0;
    logic        op_prot_hit = 1'b0;
    logic        sck, cs_n, mosi, miso_out, miso_oe_n, op_start, suspend_req, abort_req;
    logic [7:0]  nv_wr_data, rx;
    logic [23:0] op_addr;
    logic [2:0]  active_protect;
    fso_state_e  op_kind;
    fso_status_s st;
    int          err_total = 0;
    int          n_tests = 0;
    int          starts = 0;
    int          susp = 0;
    int          aborts = 0;
    fso_status_one fso_status_one_inst (.core_clk(core_clk), .rst_n(rst_n), .sck(sck),
        .cs_n(cs_n), .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .wp_n(wp_n),
        .status_one_nonvolatile(nv_st), .config_one_nonvolatile(nv_cf),
        .nv_wr_data(nv_wr_data), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
        .active_protect(active_protect), .suspend_req(suspend_req), .abort_req(abort_req),
        .op_done(op_done), .op_fail(op_fail), .op_prot_hit(op_prot_hit),
        .status_one_volatile(st));
    fso_host_model fso_host_model_inst (.sck(sck), .cs_n(cs_n), .mosi(mosi),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n));
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        starts += (op_start === 1'b1);
        susp += (suspend_req === 1'b1);
        aborts += (abort_req === 1'b1);
    end
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] tx[$]);
        logic [7:0] r;
        fso_host_model_inst.xfer(tx, 0, r);
    endtask
    task automatic rd(logic [7:0] exp);
        logic [7:0] r;
        fso_host_model_inst.xfer('{OPC_READ_STATUS1}, 1, r);
        cmp("status", exp, r);
    endtask
    // Engine result: one-cycle done with its qualifiers
    task automatic done(logic f, logic p);
        @(posedge core_clk) #1;
        op_done = 1'b1;
        op_fail = f;
        op_prot_hit = p;
        @(posedge core_clk) #1;
        op_done = 1'b0;
        op_fail = 1'b0;
        op_prot_hit = 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    initial begin
        #200us;
        err_total++;
        tally_and_finish();
    end
    initial begin
        // Assert after time zero so the link side sees a real reset edge
        #1 rst_n = 1'b0;
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge core_clk);
        rd(8'h9C);
        cmp("miso enable", 8'h01, {7'h00, miso_oe_n});
        fso_host_model_inst.xfer('{OPC_ANY_READ, 8'h80, 8'h00, 8'h00}, 1, rx);
        cmp("any read", 8'h9C, rx);
        fso_host_model_inst.xfer('{OPC_READ_STATUS2}, 1, rx);
        cmp("status two", 8'h00, rx);
        @(posedge core_clk) #1 nv_st = 8'h00;
        rd(8'h00);
        cmd('{OPC_PROGRAM, 8'h01, 8'h02, 8'h03});
        cmp("starts", 0, starts[7:0]);
        cmd('{OPC_WRITE_ENABLE});
        rd(8'h02);
        cmd('{OPC_WRITE_DISABLE});
        rd(8'h00);
        cmd('{OPC_WRITE_ENABLE});
        cmd('{OPC_PROGRAM, 8'h01, 8'h02, 8'h03});
        cmp("kind", 8'(ST_PROGRAM), 8'(op_kind));
        cmd('{OPC_WRITE_DISABLE});
        rd(8'h03);
        done(1'b1, 1'b0);
        rd(8'h43);
        cmd('{OPC_PROGRAM, 8'h01, 8'h02, 8'h03});
        cmp("starts", 1, starts[7:0]);
        cmd('{OPC_CLEAR_A});
        rd(8'h02);
        cmd('{OPC_WRITE_DISABLE});
        cmd('{OPC_WRITE_ENABLE});
        cmd('{OPC_PROGRAM, 8'h00, 8'h10, 8'h00});
        cmp("addr", 8'h10, op_addr[15:8]);
        cmd('{OPC_ERASE_SUSPEND});
        cmp("suspends", 0, susp[7:0]);
        cmd('{OPC_PROG_SUSPEND});
        cmp("suspends", 1, susp[7:0]);
        cmd('{OPC_SUSPEND_ANY});
        cmp("suspends", 2, susp[7:0]);
        done(1'b0, 1'b0);
        rd(8'h00);
        cmd('{OPC_WRITE_ENABLE});
        cmd('{OPC_ERASE, 8'h04, 8'h00, 8'h00});
        cmp("addr", 8'h04, op_addr[23:16]);
        done(1'b0, 1'b1);
        rd(8'h23);
        cmd('{OPC_CLEAR_B});
        rd(8'h02);
        @(posedge core_clk) #1 nv_st = 8'h04;
        cmd('{OPC_BULK_ERASE});
        cmp("starts", 3, starts[7:0]);
        cmp("protect", 8'h01, {5'h00, active_protect});
        rd(8'h06);
        @(posedge core_clk) #1 nv_st = 8'h00;
        cmd('{OPC_BULK_ERASE});
        cmp("starts", 4, starts[7:0]);
        done(1'b0, 1'b1);
        rd(8'h00);
        cmd('{OPC_WRITE_ENABLE});
        cmd('{OPC_REG_WRITE, 8'hFF});
        cmp("kind", 8'(ST_REGWR), 8'(op_kind));
        cmp("nv image", 8'h9C, nv_wr_data);
        done(1'b0, 1'b0);
        @(posedge core_clk) #1 nv_st = 8'h9C;
        rd(8'h9C);
        @(posedge core_clk) #1 wp_n = 1'b0;
        cmd('{OPC_WRITE_ENABLE});
        cmd('{OPC_REG_WRITE, 8'h00});
        cmp("starts", 5, starts[7:0]);
        rd(8'h9E);
        @(posedge core_clk) #1 wp_n = 1'b1;
        nv_st = 8'h00;
        nv_cf = 8'h08;
        cmd('{OPC_REG_WRITE, 8'h14});
        cmp("nv image", 8'h00, nv_wr_data);
        rd(8'h17);
        done(1'b0, 1'b0);
        rd(8'h14);
        cmd('{OPC_WRITE_ENABLE});
        cmd('{OPC_ANY_WRITE, 8'h80, 8'h00, 8'h00, 8'h08});
        cmp("addr", 8'h80, op_addr[23:16]);
        rd(8'h0B);
        done(1'b1, 1'b0);
        rd(8'h4B);
        cmd('{OPC_CLEAR_A});
        cmd('{OPC_WRITE_DISABLE});
        rd(8'h08);
        cmd('{OPC_WRITE_ENABLE});
        cmd('{OPC_PROGRAM, 8'h00, 8'h00, 8'h00});
        cmd('{OPC_SOFT_RESET});
        cmp("aborts", 1, aborts[7:0]);
        rd(8'h00);
        tally_and_finish();
    end
endmodule

/* hdl/fso_pkg.sv */
// Shared constants and types for the volatile first status register block
package fso_pkg;

    // Link opcodes
    localparam logic [7:0] OPC_READ_STATUS1  = 8'h05;
    localparam logic [7:0] OPC_READ_STATUS2  = 8'h07;
    localparam logic [7:0] OPC_ANY_READ      = 8'h65;
    localparam logic [7:0] OPC_REG_WRITE     = 8'h01;
    localparam logic [7:0] OPC_ANY_WRITE     = 8'h71;
    localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_CLEAR_A       = 8'h30;
    localparam logic [7:0] OPC_CLEAR_B       = 8'h82;
    localparam logic [7:0] OPC_ERASE_SUSPEND = 8'h75;
    localparam logic [7:0] OPC_PROG_SUSPEND  = 8'h85;
    localparam logic [7:0] OPC_SUSPEND_ANY   = 8'hB0;
    localparam logic [7:0] OPC_PROGRAM       = 8'h02;
    localparam logic [7:0] OPC_ERASE         = 8'hD8;
    localparam logic [7:0] OPC_BULK_ERASE    = 8'h60;
    localparam logic [7:0] OPC_SOFT_RESET    = 8'hF0;

    // Register addresses seen by the any-register commands
    localparam logic [23:0] ADDR_STATUS_ONE_NONVOLATILE = 24'h00_0000;
    localparam logic [23:0] ADDR_STATUS_ONE_VOLATILE  = 24'h80_0000;

    // Bit count at which each part of a frame is complete, and the count at which it stops
    localparam logic [5:0] CNT_OPC_END  = 6'h07;
    localparam logic [5:0] CNT_WRR_END  = 6'h0F;
    localparam logic [5:0] CNT_ADDR_END = 6'h1F;
    localparam logic [5:0] CNT_ANY_REGISTER_WRITE_CMD_END = 6'h27;
    localparam logic [5:0] CNT_MAX      = 6'h3F;

    // Field positions in the non-volatile images
    localparam int NV_LOCK_BIT = 7;
    localparam int NV_BP_HI    = 4;
    localparam int NV_BP_LO    = 2;
    localparam int CFG_VOL_BIT = 3;

    // Values after reset
    localparam logic       WEL_RST  = 1'h0;
    localparam logic       ERR_RST  = 1'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PROGRAM,
        ST_ERASE,
        ST_BULK,
        ST_REGWR,
        ST_FAULT
    } fso_state_e;

    typedef struct packed {
        logic       register_lock_mirror;
        logic       program_error;
        logic       erase_error;
        logic [2:0] protect_bits;
        logic       write_enable_latch;
        logic       write_in_progress;
    } fso_status_s;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [7:0]  data;
    } fso_cmd_s;

endpackage

/* hdl/fso_status_one.sv */
// Volatile first status register with serial command front end
`timescale 1ns/1ps
module fso_status_one
    import fso_pkg::*;
(
    // Core clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Serial link
    input  wire logic        sck,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    output logic             miso_out,
    output logic             miso_oe_n,
    // Write-protect pin
    input  wire logic        wp_n,
    // Non-volatile store
    input  wire logic [7:0]  status_one_nonvolatile,
    input  wire logic [7:0]  config_one_nonvolatile,
    output logic      [7:0]  nv_wr_data,
    // Array engine
    output logic             op_start,
    output fso_state_e       op_kind,
    output logic      [23:0] op_addr,
    output logic      [2:0]  active_protect,
    output logic             suspend_req,
    output logic             abort_req,
    input  wire logic        op_done,
    input  wire logic        op_fail,
    input  wire logic        op_prot_hit,
    // Register view
    output fso_status_s      status_one_volatile
);

    // ---------------- Link domain ----------------
    logic [5:0]  bit_cnt;
    logic [31:0] in_sr;
    logic [31:0] in_next;
    logic [7:0]  opc_reg;
    logic        rd_go;
    logic        rd_hit;
    logic        rd_open;
    logic        rd_hit_next;
    logic [2:0]  tx_idx;
    logic [7:0]  tx_byte;
    logic [7:0]  tx_src;
    logic        miso_reg;
    logic [7:0]  stat_sync;
    logic        tgl_reg;
    fso_cmd_s    cmd_q;
    fso_cmd_s    cmd_next;
    logic        short_hit;
    logic        fire;
    logic        at_opc;
    logic [7:0]  new_opc;

    assign in_next = {in_sr[30:0], mosi};
    assign new_opc = in_next[7:0];
    assign at_opc  = bit_cnt == CNT_OPC_END;

    assign short_hit = new_opc == OPC_WRITE_ENABLE  || new_opc == OPC_WRITE_DISABLE ||
                       new_opc == OPC_CLEAR_A       || new_opc == OPC_CLEAR_B       ||
                       new_opc == OPC_SOFT_RESET    || new_opc == OPC_ERASE_SUSPEND ||
                       new_opc == OPC_PROG_SUSPEND  || new_opc == OPC_SUSPEND_ANY   ||
                       new_opc == OPC_BULK_ERASE;

    // A command takes effect once its last byte is in
    assign fire = (at_opc && short_hit) ||
                  (bit_cnt == CNT_WRR_END && opc_reg == OPC_REG_WRITE) ||
                  (bit_cnt == CNT_ADDR_END &&
                   (opc_reg == OPC_PROGRAM || opc_reg == OPC_ERASE)) ||
                  (bit_cnt == CNT_ANY_REGISTER_WRITE_CMD_END && opc_reg == OPC_ANY_WRITE);

    assign cmd_next.opcode = at_opc ? new_opc : opc_reg;
    assign cmd_next.addr   = (bit_cnt == CNT_ANY_REGISTER_WRITE_CMD_END) ? in_next[31:8] : in_next[23:0];
    assign cmd_next.data   = in_next[7:0];

    assign rd_open = (at_opc && (new_opc == OPC_READ_STATUS1 ||
                                 new_opc == OPC_READ_STATUS2)) ||
                     (bit_cnt == CNT_ADDR_END && opc_reg == OPC_ANY_READ);
    // Second status register is outside this block and reads as zero
    assign rd_hit_next = at_opc ? (new_opc == OPC_READ_STATUS1)
                                : (in_next[23:0] == ADDR_STATUS_ONE_VOLATILE);

    assign tx_src    = rd_hit ? stat_sync : BYTE_RST;
    assign miso_out  = miso_reg;
    assign miso_oe_n = ~rd_go;

    // Frame state is cleared by the frame's own select going high
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt <= '0;
            in_sr   <= '0;
            opc_reg <= BYTE_RST;
            rd_go   <= 1'b0;
            rd_hit  <= 1'b0;
        end else begin
            in_sr <= in_next;
            if (bit_cnt != CNT_MAX) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
            if (at_opc) begin
                opc_reg <= new_opc;
            end
            if (rd_open) begin
                rd_go  <= 1'b1;
                rd_hit <= rd_hit_next;
            end
        end
    end

    // Data leaves on the falling edge; status refreshes every byte for polling
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            tx_idx   <= '0;
            tx_byte  <= BYTE_RST;
            miso_reg <= 1'b0;
        end else if (rd_go) begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == 3'h0) begin
                tx_byte  <= tx_src;
                miso_reg <= tx_src[7];
            end else begin
                miso_reg <= tx_byte[~tx_idx];
            end
        end
    end

    // Payload is held until the next command, so the core reads it stably
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            tgl_reg <= 1'b0;
            cmd_q   <= '0;
        end else if (fire) begin
            tgl_reg <= ~tgl_reg;
            cmd_q   <= cmd_next;
        end
    end

    // ---------------- Core domain ----------------
    logic        tgl_sync;
    logic        tgl_seen_reg;
    logic        wp_n_sync;
    logic        cmd_ev;
    fso_state_e  state_reg;
    fso_state_e  state_next;
    logic        perr_reg;
    logic        perr_next;
    logic        eerr_reg;
    logic        eerr_next;
    logic        wel_reg;
    logic        wel_next;
    logic [2:0]  bp_vol_reg;
    logic [2:0]  bp_vol_next;
    fso_status_s status_reg;
    logic        op_start_reg;
    fso_state_e  op_kind_reg;
    logic [23:0] op_addr_reg;
    logic [7:0]  nv_wr_reg;
    logic [2:0]  protect_reg;
    logic        suspend_reg;
    logic        abort_reg;

    fso_sync #(.WIDTH(1)) u_tgl_sync (
        .clk (core_clk),
        .d   (tgl_reg),
        .q   (tgl_sync)
    );

    fso_sync #(.WIDTH(1)) u_wp_sync (
        .clk (core_clk),
        .d   (wp_n),
        .q   (wp_n_sync)
    );

    fso_sync #(.WIDTH(8)) u_stat_sync (
        .clk (sck),
        .d   (status_reg),
        .q   (stat_sync)
    );

    logic       vol_sel;
    logic [2:0] nv_bp;
    logic [2:0] active_bp;
    logic       lock_nv;
    logic       reg_locked;
    logic       busy;
    logic       op_run;
    logic [7:0] opc;
    logic       sr1_write;
    logic       idle_ev;
    logic       mod_ok;
    logic       do_write_enable_cmd;
    logic       do_write_disable_cmd;
    logic       do_clear_status_cmd;
    logic       do_rst;
    logic       do_regwr;
    logic       do_prog;
    logic       do_erase;
    logic       do_bulk;
    logic       do_erase_suspend_cmd;
    logic       do_program_suspend_cmd;
    logic       do_start;
    logic       fin;
    logic       set_perr;
    logic       set_eerr;
    logic       fin_ok;
    logic [2:0] bp_write;

    assign cmd_ev     = tgl_sync ^ tgl_seen_reg;
    assign vol_sel    = config_one_nonvolatile[CFG_VOL_BIT];
    assign nv_bp      = status_one_nonvolatile[NV_BP_HI:NV_BP_LO];
    assign active_bp  = vol_sel ? bp_vol_reg : nv_bp;
    assign lock_nv    = status_one_nonvolatile[NV_LOCK_BIT];
    assign reg_locked = lock_nv && !wp_n_sync;
    assign busy       = state_reg != ST_IDLE;
    assign op_run     = busy && state_reg != ST_FAULT;
    assign opc        = cmd_q.opcode;

    assign sr1_write = opc == OPC_REG_WRITE ||
                       (opc == OPC_ANY_WRITE &&
                        (cmd_q.addr == ADDR_STATUS_ONE_VOLATILE || cmd_q.addr == ADDR_STATUS_ONE_NONVOLATILE));

    assign idle_ev  = cmd_ev && !busy;
    assign mod_ok   = idle_ev && wel_reg;
    assign do_write_enable_cmd  = idle_ev && opc == OPC_WRITE_ENABLE;
    assign do_write_disable_cmd  = idle_ev && opc == OPC_WRITE_DISABLE;
    assign do_clear_status_cmd  = cmd_ev && (opc == OPC_CLEAR_A || opc == OPC_CLEAR_B);
    assign do_rst   = cmd_ev && opc == OPC_SOFT_RESET;
    assign do_regwr = mod_ok && sr1_write && !reg_locked;
    assign do_prog  = mod_ok && opc == OPC_PROGRAM;
    assign do_erase = mod_ok && opc == OPC_ERASE;
    assign do_bulk  = mod_ok && opc == OPC_BULK_ERASE && active_bp == 3'h0;
    assign do_start = do_regwr || do_prog || do_erase || do_bulk;

    assign do_erase_suspend_cmd = cmd_ev && (opc == OPC_ERASE_SUSPEND || opc == OPC_SUSPEND_ANY) &&
                     (state_reg == ST_ERASE || state_reg == ST_BULK);
    assign do_program_suspend_cmd = cmd_ev && (opc == OPC_PROG_SUSPEND || opc == OPC_SUSPEND_ANY) &&
                     state_reg == ST_PROGRAM;

    assign fin      = op_done && op_run;
    assign set_perr = fin && ((state_reg == ST_PROGRAM && (op_fail || op_prot_hit)) ||
                              (state_reg == ST_REGWR && op_fail));
    // Protected sectors met by a whole-array erase are skipped silently
    assign set_eerr = fin && ((state_reg == ST_ERASE && (op_fail || op_prot_hit)) ||
                              (state_reg == ST_BULK && op_fail));
    assign fin_ok   = fin && !set_perr && !set_eerr;

    // Volatile mode keeps the stored protection bits as they are
    assign bp_write = vol_sel ? nv_bp : cmd_q.data[NV_BP_HI:NV_BP_LO];

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (do_regwr) begin
                    state_next = ST_REGWR;
                end else if (do_prog) begin
                    state_next = ST_PROGRAM;
                end else if (do_erase) begin
                    state_next = ST_ERASE;
                end else if (do_bulk) begin
                    state_next = ST_BULK;
                end
            end
            ST_PROGRAM, ST_ERASE, ST_BULK, ST_REGWR: begin
                if (set_perr || set_eerr) begin
                    state_next = ST_FAULT;
                end else if (fin) begin
                    state_next = ST_IDLE;
                end
            end
            ST_FAULT: begin
                if (do_clear_status_cmd) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
        if (do_rst && !(set_perr || set_eerr)) begin
            state_next = ST_IDLE;
        end
    end

    // Flags update in the finishing cycle while busy still reads one
    assign perr_next = set_perr || (perr_reg && !(do_clear_status_cmd || do_rst));
    assign eerr_next = set_eerr || (eerr_reg && !(do_clear_status_cmd || do_rst));

    always_comb begin
        wel_next = wel_reg;
        if (do_write_enable_cmd) begin
            wel_next = 1'b1;
        end
        if (do_write_disable_cmd || fin_ok) begin
            wel_next = 1'b0;
        end
        if (do_rst) begin
            wel_next = WEL_RST;
        end
    end

    always_comb begin
        bp_vol_next = bp_vol_reg;
        if (!vol_sel || do_rst) begin
            bp_vol_next = nv_bp;
        end else if (do_regwr) begin
            bp_vol_next = cmd_q.data[NV_BP_HI:NV_BP_LO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tgl_seen_reg <= 1'b0;
            state_reg    <= ST_IDLE;
            perr_reg     <= ERR_RST;
            eerr_reg     <= ERR_RST;
            wel_reg      <= WEL_RST;
            bp_vol_reg   <= nv_bp;
        end else begin
            tgl_seen_reg <= tgl_sync;
            state_reg    <= state_next;
            perr_reg     <= perr_next;
            eerr_reg     <= eerr_next;
            wel_reg      <= wel_next;
            bp_vol_reg   <= bp_vol_next;
        end
    end

    // Register view built from next values so it matches the state flops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status_reg <= '0;
        end else begin
            status_reg.register_lock_mirror <= lock_nv;
            status_reg.program_error        <= perr_next;
            status_reg.erase_error          <= eerr_next;
            status_reg.protect_bits         <= bp_vol_next;
            status_reg.write_enable_latch   <= wel_next;
            status_reg.write_in_progress    <= state_next != ST_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            op_start_reg <= 1'b0;
            op_kind_reg  <= ST_IDLE;
            op_addr_reg  <= '0;
            nv_wr_reg    <= BYTE_RST;
            protect_reg  <= '0;
            suspend_reg  <= 1'b0;
            abort_reg    <= 1'b0;
        end else begin
            op_start_reg <= do_start;
            suspend_reg  <= do_erase_suspend_cmd || do_program_suspend_cmd;
            abort_reg    <= do_rst;
            protect_reg  <= active_bp;
            if (do_start) begin
                op_kind_reg <= state_next;
                op_addr_reg <= cmd_q.addr;
            end
            if (do_regwr) begin
                nv_wr_reg <= {cmd_q.data[NV_LOCK_BIT], status_one_nonvolatile[6:5],
                              bp_write, status_one_nonvolatile[1:0]};
            end
        end
    end

    assign op_start            = op_start_reg;
    assign op_kind             = op_kind_reg;
    assign op_addr             = op_addr_reg;
    assign nv_wr_data          = nv_wr_reg;
    assign active_protect      = protect_reg;
    assign suspend_req         = suspend_reg;
    assign abort_req           = abort_reg;
    assign status_one_volatile = status_reg;

endmodule

/* hdl/fso_sync.sv */
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module fso_sync
    import fso_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Destination clock
    input  wire logic             clk,
    // Level in and synchronised level out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // No reset: pure data path, settles within two edges
    always_ff @(posedge clk) begin
        meta_reg <= d;
        sync_reg <= meta_reg;
    end

    assign q = sync_reg;

endmodule
